// ---- ebus_write_unit.sv ----
// External bus write enable unit with APB register access.
// Assumes pins arrive asynchronous and an outside pad resolves enables.
//
// The placing of the registers and register access over APB were decided locally.
`include "ebus_defs.svh"
`default_nettype none
module ebus_write_unit #(
   parameter bit WIDE = 1'b1,
   parameter int HALF_DIV = `EB_HALF_DIV
) (
   // Clock and reset.
   input wire logic CLK,
   input wire logic RST,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Pins from the board.
   input wire logic BUS_HOLD,
   input wire logic PIN_FLOAT_TEST_MODE,
   input wire logic ADDRESS_DRIVE_STRAP,
   input wire logic [15:0] AD_IN,
   // Multiplexed bus.
   output logic [15:0] AD_OUT,
   output logic AD_LO_OE_N,
   output logic AD_HI_OE_N,
   // Address buses.
   output logic [19:0] DEMUXED_ADDRESS_BUS,
   output logic [7:0] UPPER_ADDRESS_ONLY_LINES,
   output logic UPPER_ADDRESS_OE_N,
   // Strobes and enables.
   output logic LOW_LANE_WRITE_EN_N,
   output logic LOW_LANE_WRITE_OE_N,
   output logic HIGH_LANE_WRITE_EN_N,
   output logic HIGH_LANE_WRITE_OE_N,
   output logic SINGLE_WRITE_EN_N,
   output logic SINGLE_WRITE_OE_N,
   output logic WRITE_STROBE_N,
   output logic WRITE_STROBE_OE_N,
   output logic READ_STROBE_N,
   output logic UPPER_LANE_ENABLE_N,
   output logic UPPER_MEMORY_SELECT_N,
   output logic LOWER_MEMORY_SELECT_N,
   output logic BUS_CLOCK_OUT
);
   import ebus_pkg::*;

   bus_state_t state_q;
   logic half_q, tick_q, clk_out_q;
   logic [7:0] div_q;
   logic hold_m, hold_s, flt_m, flt_s, strap_m, strap_s;
   logic [15:0] ad_m, ad_s;
   logic strap_q, init_q;
   logic dis_up_q, dis_lo_q;
   logic [15:0] seg_c_q, seg_d_q, seg_s_q, seg_e_q, off_q, wdata_q, rdata_q;
   logic [6:0] cmd_q;
   logic pend_q;
   logic [19:0] phys_q, phys_d;
   logic is_io_d;
   logic write_q, ube_q, space_up_q, space_lo_q;
   logic busy, t1b, data_ph, wr_ph, wr_early, rd_ph, flt, da_eff, addr_mux;
   logic setup, acc_wr, launch;

   ebus_addr_former u_former (
      .kind(ref_kind_t'(cmd_q[2:0])),
      .offset(off_q),
      .seg_code(seg_c_q),
      .seg_data(seg_d_q),
      .seg_stack(seg_s_q),
      .seg_extra(seg_e_q),
      .phys(phys_d),
      .is_io(is_io_d)
   );

   // Pin synchronisers.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         {hold_m, hold_s, flt_m, flt_s} <= 4'h0;
         ad_m <= 16'h0000;
         ad_s <= 16'h0000;
      end else begin
         hold_m <= BUS_HOLD;
         hold_s <= hold_m;
         flt_m <= PIN_FLOAT_TEST_MODE;
         flt_s <= flt_m;
         ad_m <= AD_IN;
         ad_s <= ad_m;
      end
   end

   // Strap synchroniser runs through reset so the catch sees the pin.
   always_ff @(posedge CLK) begin
      strap_m <= ADDRESS_DRIVE_STRAP;
      strap_s <= strap_m;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         init_q <= 1'b1;
         strap_q <= 1'b1;
      end else if (init_q) begin
         init_q <= 1'b0;
         strap_q <= strap_s;
      end
   end

   // Half bus clock divider.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         div_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (div_q == 8'(HALF_DIV - 1)) begin
         div_q <= 8'h00;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 8'h01;
         tick_q <= 1'b0;
      end
   end

   assign setup = PSEL && !PENABLE;
   assign acc_wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   assign launch = tick_q && half_q && state_q == ST_IDLE && pend_q && !hold_s;

   // APB answer, one access cycle.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         PREADY <= setup;
         PSLVERR <= setup && (PADDR > `EB_RDATA || PADDR[1:0] != 2'b00 ||
            (PWRITE && PADDR == `EB_CMD && (pend_q || busy)) ||
            (PWRITE && PADDR >= `EB_STATUS));
         PRDATA <= 32'h00000000;
         if (setup && !PWRITE) begin
            case (PADDR)
               `EB_CTRL: PRDATA <= {30'h0, dis_lo_q, dis_up_q};
               `EB_SEG_CODE: PRDATA <= {16'h0, seg_c_q};
               `EB_SEG_DATA: PRDATA <= {16'h0, seg_d_q};
               `EB_SEG_STACK: PRDATA <= {16'h0, seg_s_q};
               `EB_SEG_EXTRA: PRDATA <= {16'h0, seg_e_q};
               `EB_OFFSET: PRDATA <= {16'h0, off_q};
               `EB_WDATA: PRDATA <= {16'h0, wdata_q};
               `EB_CMD: PRDATA <= {25'h0, cmd_q};
               `EB_STATUS: PRDATA <= {28'h0, hold_s, strap_q, pend_q, busy};
               `EB_LAST_ADDR: PRDATA <= {12'h0, phys_q};
               `EB_RDATA: PRDATA <= {16'h0, rdata_q};
               default: PRDATA <= 32'h00000000;
            endcase
         end
      end
   end

   // Register writes and command pending flag.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         {dis_up_q, dis_lo_q} <= 2'b00;
         {seg_c_q, seg_d_q, seg_s_q, seg_e_q} <= 64'h0;
         off_q <= 16'h0000;
         wdata_q <= 16'h0000;
         cmd_q <= 7'h00;
         pend_q <= 1'b0;
      end else begin
         if (launch)
            pend_q <= 1'b0;
         if (acc_wr) begin
            case (PADDR)
               `EB_CTRL: begin
                  dis_up_q <= PWDATA[`EB_CTRL_DIS_UP];
                  dis_lo_q <= PWDATA[`EB_CTRL_DIS_LO];
               end
               `EB_SEG_CODE: seg_c_q <= PWDATA[15:0];
               `EB_SEG_DATA: seg_d_q <= PWDATA[15:0];
               `EB_SEG_STACK: seg_s_q <= PWDATA[15:0];
               `EB_SEG_EXTRA: seg_e_q <= PWDATA[15:0];
               `EB_OFFSET: off_q <= PWDATA[15:0];
               `EB_WDATA: wdata_q <= PWDATA[15:0];
               `EB_CMD: begin
                  cmd_q <= PWDATA[6:0];
                  pend_q <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // Bus cycle sequencer, t1 to t4, one bus clock (two half bus clock ticks) per state.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
         half_q <= 1'b1;
      end else if (tick_q) begin
         half_q <= !half_q;
         if (half_q) begin
            case (state_q)
               ST_IDLE: if (launch) state_q <= ST_T1;
               ST_T1: state_q <= ST_T2;
               ST_T2: state_q <= ST_T3;
               ST_T3: state_q <= ST_T4;
               ST_T4: state_q <= ST_IDLE;
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Cycle attributes latched at launch; read data taken in t4.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         phys_q <= 20'h00000;
         {write_q, ube_q, space_up_q, space_lo_q} <= 4'b0100;
         rdata_q <= 16'h0000;
      end else begin
         if (launch) begin
            phys_q <= phys_d;
            write_q <= cmd_q[`EB_CMD_WRITE];
            ube_q <= WIDE ? (cmd_q[`EB_CMD_BYTE] && !phys_d[0]) : 1'b1;
            space_up_q <= cmd_q[`EB_CMD_SPACE_UP] && !is_io_d;
            space_lo_q <= cmd_q[`EB_CMD_SPACE_LO] && !is_io_d;
         end
         if (state_q == ST_T4 && !half_q && !write_q)
            rdata_q <= ad_s;
      end
   end

   assign busy = state_q != ST_IDLE;
   assign t1b = state_q == ST_T1 && half_q;
   assign data_ph = state_q == ST_T2 || state_q == ST_T3 || state_q == ST_T4;
   assign wr_ph = write_q && (state_q == ST_T2 || state_q == ST_T3);
   assign wr_early = write_q && (t1b || state_q == ST_T2 ||
      state_q == ST_T3);
   assign rd_ph = !write_q && (state_q == ST_T2 || state_q == ST_T3);
   assign flt = hold_s || flt_s;
   assign da_eff = strap_q && ((space_up_q && dis_up_q) ||
      (space_lo_q && dis_lo_q));
   assign addr_mux = t1b && !da_eff;

   // Address buses and multiplexed bus.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         DEMUXED_ADDRESS_BUS <= 20'h00000;
         AD_OUT <= 16'h0000;
         {AD_LO_OE_N, AD_HI_OE_N, UPPER_ADDRESS_OE_N} <= 3'b111;
         UPPER_ADDRESS_ONLY_LINES <= 8'h00;
         clk_out_q <= 1'b0;
      end else begin
         clk_out_q <= !half_q;
         DEMUXED_ADDRESS_BUS <= busy ? phys_q : 20'h00000;
         AD_OUT <= 16'h0000;
         AD_LO_OE_N <= 1'b1;
         AD_HI_OE_N <= 1'b1;
         if (!flt && addr_mux) begin
            AD_OUT <= phys_q[15:0];
            AD_LO_OE_N <= 1'b0;
            AD_HI_OE_N <= !WIDE;
         end else if (!flt && data_ph && write_q) begin
            AD_OUT <= wdata_q;
            AD_LO_OE_N <= 1'b0;
            AD_HI_OE_N <= !WIDE;
         end
         // Upper address lines in data portion.
         // Address only from t2 under disable.
         UPPER_ADDRESS_ONLY_LINES <= phys_q[15:8];
         UPPER_ADDRESS_OE_N <= WIDE || flt || !(addr_mux || data_ph);
      end
   end

   // Strobes, write enables and selects.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         {LOW_LANE_WRITE_EN_N, HIGH_LANE_WRITE_EN_N} <= 2'b11;
         {SINGLE_WRITE_EN_N, WRITE_STROBE_N, READ_STROBE_N} <= 3'b111;
         {LOW_LANE_WRITE_OE_N, HIGH_LANE_WRITE_OE_N} <= 2'b11;
         {SINGLE_WRITE_OE_N, WRITE_STROBE_OE_N} <= 2'b11;
         {UPPER_LANE_ENABLE_N, UPPER_MEMORY_SELECT_N} <= 2'b11;
         LOWER_MEMORY_SELECT_N <= 1'b1;
      end else begin
         // Low lane gated by address bit zero.
         LOW_LANE_WRITE_EN_N <= phys_q[0] || !wr_early;
         // High lane gated by upper lane enable.
         // High lane tied to upper lanes.
         HIGH_LANE_WRITE_EN_N <= ube_q || !wr_early;
         // Single enable for every byte write.
         SINGLE_WRITE_EN_N <= !wr_early;
         // Enables float in hold or test.
         LOW_LANE_WRITE_OE_N <= !WIDE || flt;
         HIGH_LANE_WRITE_OE_N <= !WIDE || flt;
         SINGLE_WRITE_OE_N <= WIDE || flt;
         WRITE_STROBE_N <= !wr_ph;
         WRITE_STROBE_OE_N <= flt;
         READ_STROBE_N <= !rd_ph;
         UPPER_LANE_ENABLE_N <= !busy || ube_q;
         UPPER_MEMORY_SELECT_N <= !(busy && space_up_q);
         LOWER_MEMORY_SELECT_N <= !(busy && space_lo_q);
      end
   end

   assign BUS_CLOCK_OUT = clk_out_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   a_low_lane_gate: assert property (
      !LOW_LANE_WRITE_EN_N |-> $past(write_q && !phys_q[0]))
      else $error("Low lane enable without even write.");
   a_high_lane_gate: assert property (
      !HIGH_LANE_WRITE_EN_N |-> $past(write_q && !ube_q))
      else $error("High lane enable without upper lane write.");
   a_enable_float: assert property (
      flt |=> LOW_LANE_WRITE_OE_N && HIGH_LANE_WRITE_OE_N &&
         SINGLE_WRITE_OE_N)
      else $error("Write enable driven during hold or test.");
   a_strobe_float: assert property (
      hold_s |=> WRITE_STROBE_OE_N)
      else $error("Write strobe driven during hold.");
   a_single_early: assert property (
      $fell(WRITE_STROBE_N) |-> !SINGLE_WRITE_EN_N || WIDE)
      else $error("Single enable not early with write.");
   a_addr_hold: assert property (
      state_q == ST_T3 |=> DEMUXED_ADDRESS_BUS == phys_q)
      else $error("Demuxed address lost in cycle.");
   a_da_float: assert property (
      (t1b && da_eff) |=> AD_LO_OE_N)
      else $error("Multiplexed bus driven under disable.");
   a_strap_wins: assert property (
      (!strap_q && t1b && !flt) |=> !AD_LO_OE_N)
      else $error("Disable honoured despite low strap.");
   a_early_addr: assert property (
      (state_q == ST_T1 && !half_q) |=> DEMUXED_ADDRESS_BUS == phys_q)
      else $error("Demuxed address not early.");
   a_upper_data: assert property (
      (!WIDE && !flt && state_q == ST_T2) |=>
         !UPPER_ADDRESS_OE_N && UPPER_ADDRESS_ONLY_LINES == phys_q[15:8])
      else $error("Upper address lines idle in data portion.");
   a_read_strobe: assert property (
      rd_ph |=> !READ_STROBE_N)
      else $error("Read strobe missing on read.");

   c_write_cycle: cover property (wr_ph && state_q == ST_T3);
   c_read_cycle: cover property (rd_ph && state_q == ST_T3);
   c_disable_cycle: cover property (t1b && da_eff);
   c_hold_busy: cover property (hold_s && busy);
endmodule
`default_nettype wire

// ---- ebus_defs.svh ----
// Constants for the external bus write enable unit.
// Assumes a 40 MHz CLK and an APB master with 8-bit byte addresses.
//
// What this block does
// - Wide variant: low lane write enable low only if address bit zero and write low.
// - Wide variant: high lane write enable low only if upper lane and write low.
// - Byte write enables float during bus hold and pin float test mode.
// - Narrow variant: single write enable low on every byte write, early timing.
// - Write strobe marks a write and floats during bus hold and reset.
// - Physical address is segment shifted left four plus offset, 20 bits.
// - Code, data, stack and extra segments chosen by the kind of reference.
// - Short port numbers are zero extended; long ones come from the offset register.
// - Demuxed address holds t1 to t4; multiplexed bus carries address in t1 only.
// - Address disable for a select space floats the multiplexed address phase.
// - Narrow variant drives upper address lines in the data portion unless bus hold or pin float test mode floats them.
// - Strap held low in reset overrides both address disable bits.
// - Narrow with disable: low lines data only, upper lines address in t2 to t4.
// - Demuxed address valid half a bus clock before multiplexed address.
// - Byte write enables start in the second half of t1, half a bus clock after the demuxed address.
// - High lane write enable belongs to upper lanes and sits high in reset.
// - Read strobe goes low whenever a word or byte is read.
`ifndef EBUS_DEFS_SVH
`define EBUS_DEFS_SVH
`define EB_CTRL 8'h00
`define EB_SEG_CODE 8'h04
`define EB_SEG_DATA 8'h08
`define EB_SEG_STACK 8'h0c
`define EB_SEG_EXTRA 8'h10
`define EB_OFFSET 8'h14
`define EB_WDATA 8'h18
`define EB_CMD 8'h1c
`define EB_STATUS 8'h20
`define EB_LAST_ADDR 8'h24
`define EB_RDATA 8'h28
`define EB_CTRL_DIS_UP 0
`define EB_CTRL_DIS_LO 1
`define EB_CMD_WRITE 3
`define EB_CMD_BYTE 4
`define EB_CMD_SPACE_UP 5
`define EB_CMD_SPACE_LO 6
`define EB_SEG_SHIFT 4
`define EB_HALF_DIV 1
`endif

// ---- ebus_pkg.sv ----
// Types shared by the external bus write enable unit.
// Assumes ebus_defs.svh is compiled alongside.
`default_nettype none
package ebus_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_T1 = 3'b001,
      ST_T2 = 3'b011,
      ST_T3 = 3'b010,
      ST_T4 = 3'b110
   } bus_state_t;
   typedef enum logic [2:0] {
      REF_CODE = 3'h0,
      REF_DATA = 3'h1,
      REF_STACK = 3'h2,
      REF_BASE_PTR = 3'h3,
      REF_STRING_DEST = 3'h4,
      REF_IO_SHORT = 3'h5,
      REF_IO_LONG = 3'h6
   } ref_kind_t;
endpackage
`default_nettype wire

// ---- ebus_addr_former.sv ----
// Physical address former: segment choice and I/O port extension.
// Assumes segment and offset values are stable while read.
`include "ebus_defs.svh"
`default_nettype none
module ebus_addr_former (
   // Reference kind and offset.
   input wire ebus_pkg::ref_kind_t kind,
   input wire logic [15:0] offset,
   // Segment values.
   input wire logic [15:0] seg_code,
   input wire logic [15:0] seg_data,
   input wire logic [15:0] seg_stack,
   input wire logic [15:0] seg_extra,
   // Result.
   output logic [19:0] phys,
   output logic is_io
);
   import ebus_pkg::*;

   function automatic logic [19:0] form(input logic [15:0] s,
                                        input logic [15:0] o);
      form = {s, 4'h0} + {4'h0, o};
   endfunction

   always_comb begin
      is_io = 1'b0;
      case (kind)
         REF_CODE: phys = form(seg_code, offset);
         REF_DATA: phys = form(seg_data, offset);
         REF_STACK, REF_BASE_PTR: phys = form(seg_stack, offset);
         REF_STRING_DEST: phys = form(seg_extra, offset);
         REF_IO_SHORT: begin
            phys = {12'h000, offset[7:0]};
            is_io = 1'b1;
         end
         REF_IO_LONG: begin
            phys = {4'h0, offset};
            is_io = 1'b1;
         end
         default: phys = form(seg_data, offset);
      endcase
   end

   a_short_port_zero: assert property (@(kind)
      kind == REF_IO_SHORT |-> phys[19:8] == 12'h000)
      else $error("Short port address not zero extended.");
endmodule
`default_nettype wire

// ---- ext_mem.sv ----
// Small external memory standing on the far side of the multiplexed bus.
// Assumes word index taken from address bits 4 to 1 and a 16-bit data bus.
`default_nettype none
module ext_mem (
   // Clock.
   input wire logic clk,
   // Bus from the device.
   input wire logic [19:0] addr,
   input wire logic [15:0] ad_out,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic lo_we_n,
   input wire logic hi_we_n,
   // Read data back to the device.
   output logic [15:0] ad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:15];
   logic [15:0] last_q = 16'h0000;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
   end
   // Each lane is written only while its own enable and the strobe are low.
   always @(posedge clk) begin
      if (wr_n === 1'b0 && lo_we_n === 1'b0) mem[addr[4:1]][7:0] <= ad_out[7:0];
      if (wr_n === 1'b0 && hi_we_n === 1'b0) mem[addr[4:1]][15:8] <= ad_out[15:8];
      if (rd_n === 1'b0) last_q <= mem[addr[4:1]];
   end
   // A released bus shows the inverse of the last word, never a held value.
   assign ad_in = (rd_n === 1'b0) ? mem[addr[4:1]] : ~last_q;
endmodule
`default_nettype wire

// ---- external_bus_write_enable_unit_test.sv ----
// Self-checking bench for the external bus write enable unit, wide and narrow variants.
// Assumes the APB register map of ebus_defs.svh and the ext_mem partner.
`include "ebus_defs.svh"
`default_nettype none
module external_bus_write_enable_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic hold = 1'b0, float_mode = 1'b0, strap = 1'b1;
   logic [15:0] ad_in, ad_out;
   logic [19:0] addr, addr_prev;
   logic ad_lo_oe_n, ucs_n, lo_we_n, lo_oe_n, hi_we_n, hi_oe_n;
   logic wr_n, wr_oe_n, rd_n, lcs_n, single_we_n, single_oe_n, upper_oe_n;
   logic [7:0] upper_lines;
   logic saw_lo, saw_hi, saw_ad, saw_sel, saw_lsel, saw_single, saw_upper;
   logic late;
   int errors = 0;
   int n_compared = 0;

   always #12.5 clk = ~clk;

   ebus_write_unit dut (.CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUS_HOLD(hold),
      .PIN_FLOAT_TEST_MODE(float_mode), .ADDRESS_DRIVE_STRAP(strap),
      .AD_IN(ad_in), .AD_OUT(ad_out), .AD_LO_OE_N(ad_lo_oe_n),
      .AD_HI_OE_N(), .DEMUXED_ADDRESS_BUS(addr),
      .UPPER_ADDRESS_ONLY_LINES(), .UPPER_ADDRESS_OE_N(),
      .LOW_LANE_WRITE_EN_N(lo_we_n), .LOW_LANE_WRITE_OE_N(lo_oe_n),
      .HIGH_LANE_WRITE_EN_N(hi_we_n), .HIGH_LANE_WRITE_OE_N(hi_oe_n),
      .SINGLE_WRITE_EN_N(), .SINGLE_WRITE_OE_N(), .WRITE_STROBE_N(wr_n),
      .WRITE_STROBE_OE_N(wr_oe_n), .READ_STROBE_N(rd_n),
      .UPPER_LANE_ENABLE_N(), .UPPER_MEMORY_SELECT_N(ucs_n),
      .LOWER_MEMORY_SELECT_N(lcs_n), .BUS_CLOCK_OUT());

   // Narrow variant beside the wide one, fed the same requests.
   ebus_write_unit #(.WIDE(1'b0)) narrow (.CLK(clk), .RST(rst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(), .PREADY(), .PSLVERR(), .BUS_HOLD(hold),
      .PIN_FLOAT_TEST_MODE(float_mode), .ADDRESS_DRIVE_STRAP(strap),
      .AD_IN(ad_in), .AD_OUT(), .AD_LO_OE_N(), .AD_HI_OE_N(),
      .DEMUXED_ADDRESS_BUS(), .UPPER_ADDRESS_ONLY_LINES(upper_lines),
      .UPPER_ADDRESS_OE_N(upper_oe_n), .LOW_LANE_WRITE_EN_N(),
      .LOW_LANE_WRITE_OE_N(), .HIGH_LANE_WRITE_EN_N(),
      .HIGH_LANE_WRITE_OE_N(), .SINGLE_WRITE_EN_N(single_we_n),
      .SINGLE_WRITE_OE_N(single_oe_n), .WRITE_STROBE_N(),
      .WRITE_STROBE_OE_N(), .READ_STROBE_N(), .UPPER_LANE_ENABLE_N(),
      .UPPER_MEMORY_SELECT_N(), .LOWER_MEMORY_SELECT_N(),
      .BUS_CLOCK_OUT());

   ext_mem partner (.clk(clk), .addr(addr), .ad_out(ad_out), .wr_n(wr_n),
      .rd_n(rd_n), .lo_we_n(lo_we_n), .hi_we_n(hi_we_n), .ad_in(ad_in));

   // Collects what the bus showed during the latest command.
   always @(posedge clk) begin
      if (lo_we_n === 1'b0) saw_lo = 1'b1;
      if (hi_we_n === 1'b0) saw_hi = 1'b1;
      if (ucs_n === 1'b0) saw_sel = 1'b1;
      if (lcs_n === 1'b0) saw_lsel = 1'b1;
      if (single_we_n === 1'b0) saw_single = 1'b1;
      if (upper_oe_n === 1'b0 && upper_lines === addr[15:8]) saw_upper = 1'b1;
      if (ad_lo_oe_n === 1'b0 && ad_out === addr[15:0] && addr !== 20'h0) begin
         saw_ad = 1'b1;
         if (addr !== addr_prev) late = 1'b1;
      end
      addr_prev = addr;
   end

   task automatic stop_test;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         stop_test;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk1(er, 1'b0);
   endtask

   task automatic run_cmd(input logic [31:0] c);
      int n;
      saw_lo = 1'b0;
      saw_hi = 1'b0;
      saw_ad = 1'b0;
      saw_sel = 1'b0;
      saw_lsel = 1'b0;
      saw_single = 1'b0;
      saw_upper = 1'b0;
      late = 1'b0;
      wr_reg(`EB_CMD, c);
      n = 0;
      do begin
         apb(1'b0, `EB_STATUS, 32'h0);
         n++;
      end while (rd[1:0] !== 2'b00 && n < 30);
      if (n >= 30) begin
         errors++;
         stop_test;
      end
   endtask

   task automatic xfer(input logic [15:0] off, input logic [15:0] wd,
         input logic [31:0] c);
      wr_reg(`EB_OFFSET, {16'h0, off});
      wr_reg(`EB_WDATA, {16'h0, wd});
      run_cmd(c);
   endtask

   task automatic do_reset(input logic s);
      strap <= s;
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      chk1(wr_oe_n, 1'b1);
      chk1(hi_we_n, 1'b1);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic t_regs;
      wr_reg(`EB_SEG_CODE, 32'h0000beef);
      apb(1'b0, `EB_SEG_CODE, 32'h0);
      chk32(rd, 32'h0000beef);
      apb(1'b1, `EB_STATUS, 32'h1);
      chk1(er, 1'b1);
      apb(1'b1, 8'h02, 32'h1);
      chk1(er, 1'b1);
      apb(1'b0, 8'h40, 32'h0);
      chk1(er, 1'b1);
      chk32(rd, 32'h0);
      $display("test regs done");
   endtask

   task automatic t_segments;
      logic [15:0] sg [4];
      int si [5];
      logic [19:0] exp;
      sg = '{16'hfff0, 16'h2345, 16'h3456, 16'h4567};
      si = '{0, 1, 2, 2, 3};
      for (int k = 0; k < 4; k++) wr_reg(8'(4 + 4 * k), {16'h0, sg[k]});
      for (int k = 0; k < 7; k++) begin
         if (k < 5) exp = {sg[si[k]], 4'h0} + 20'h00ab6;
         else if (k == 5) exp = 20'h000b6;
         else exp = 20'h00ab6;
         xfer(16'h0ab6, 16'h0, 32'(k));
         apb(1'b0, `EB_LAST_ADDR, 32'h0);
         chk32(rd, {12'h0, exp});
         chk1(saw_upper, 1'b1);
         chk1(saw_single, 1'b0);
      end
      $display("test segments done");
   endtask

   task automatic t_write_read;
      wr_reg(`EB_SEG_DATA, 32'h0);
      xfer(16'h0004, 16'h1234, 32'h09);
      chk1(saw_lo, 1'b1);
      chk1(saw_hi, 1'b1);
      chk1(saw_ad, 1'b1);
      chk1(late, 1'b0);
      chk1(saw_single, 1'b1);
      xfer(16'h0004, 16'h0000, 32'h01);
      apb(1'b0, `EB_RDATA, 32'h0);
      chk32(rd, 32'h00001234);
      xfer(16'h0004, 16'h5656, 32'h19);
      chk1(saw_lo, 1'b1);
      chk1(saw_hi, 1'b0);
      xfer(16'h0005, 16'h7878, 32'h19);
      chk1(saw_lo, 1'b0);
      chk1(saw_hi, 1'b1);
      xfer(16'h0004, 16'h0000, 32'h01);
      apb(1'b0, `EB_RDATA, 32'h0);
      chk32(rd, 32'h00007856);
      $display("test write read done");
   endtask

   task automatic t_disable;
      wr_reg(`EB_CTRL, 32'h1);
      xfer(16'h0006, 16'h0, 32'h21);
      chk1(saw_sel, 1'b1);
      chk1(saw_lsel, 1'b0);
      chk1(saw_ad, 1'b0);
      chk1(saw_upper, 1'b1);
      xfer(16'h0006, 16'h0, 32'h41);
      chk1(saw_ad, 1'b1);
      chk1(saw_lsel, 1'b1);
      wr_reg(`EB_CTRL, 32'h2);
      xfer(16'h0006, 16'h0, 32'h41);
      chk1(saw_ad, 1'b0);
      wr_reg(`EB_CTRL, 32'h0);
      $display("test disable done");
   endtask

   task automatic t_hold;
      hold <= 1'b1;
      repeat (4) @(posedge clk);
      chk1(lo_oe_n, 1'b1);
      chk1(hi_oe_n, 1'b1);
      chk1(wr_oe_n, 1'b1);
      chk1(single_oe_n, 1'b1);
      hold <= 1'b0;
      float_mode <= 1'b1;
      repeat (4) @(posedge clk);
      chk1(lo_oe_n, 1'b1);
      chk1(hi_oe_n, 1'b1);
      chk1(single_oe_n, 1'b1);
      float_mode <= 1'b0;
      repeat (4) @(posedge clk);
      chk1(lo_oe_n, 1'b0);
      chk1(single_oe_n, 1'b0);
      $display("test hold done");
   endtask

   task automatic t_strap;
      // The board holds the strap low through reset.
      do_reset(1'b0);
      apb(1'b0, `EB_STATUS, 32'h0);
      chk1(rd[2], 1'b0);
      wr_reg(`EB_CTRL, 32'h1);
      xfer(16'h0006, 16'h0, 32'h21);
      chk1(saw_ad, 1'b1);
      do_reset(1'b1);
      apb(1'b0, `EB_STATUS, 32'h0);
      chk1(rd[2], 1'b1);
      $display("test strap done");
   endtask

   initial begin
      do_reset(1'b1);
      t_regs;
      t_segments;
      t_write_read;
      t_disable;
      t_hold;
      t_strap;
      stop_test;
   end
endmodule
`default_nettype wire
